// ### autc_baud_gen.sv
// Baud tick generator: one tick every divisor plus one clocks
`timescale 1ns/1ns
module autc_baud_gen (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Divisor from software
  input wire logic [7:0] divisor,
  // Tick out
  output logic tick
);

  // Down counter
  logic [7:0] cnt_q;
  // Registered tick pulse
  logic tick_q;

  // Reload on zero; a new divisor takes effect after the current wrap
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (cnt_q == 8'h00) begin
      cnt_q <= divisor;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 8'h01;
      tick_q <= 1'b0;
    end
  end

  assign tick = tick_q;

endmodule

// ### autc_map.svh
// Register map, field positions, reset values and tick counts
//
// Operation
// - Asynchronous mode sends and receives at once.
// - Synchronous mode moves one direction at a time.
// - Ninth bit flags address frames for filtering.
// - Nine-bit select picks 9-bit frames, resets 8-bit.
// - Transmit enable gates transmission, resets cleared.
// - Synchronous receive enables override transmit enable.
`ifndef AUTC_MAP_SVH
`define AUTC_MAP_SVH

// Byte offsets on the register bus
`define AUTC_TX_DATA_OFF 8'h80
`define AUTC_RX_DATA_OFF 8'h84
`define AUTC_RSC_OFF 8'h88
`define AUTC_BAUD_OFF 8'h8C
`define AUTC_DIR_OFF 8'h90
`define AUTC_STAT_OFF 8'h94
`define AUTC_TSC_OFF 8'h98

// transmit_status_control fields
`define AUTC_TSC_CLKSRC 7
`define AUTC_TSC_NINE 6
`define AUTC_TSC_TRANSMIT_ENABLE 5
`define AUTC_TSC_SYNC 4
`define AUTC_TSC_BAUD_SPEED_RANGE_SELECT 2
`define AUTC_TSC_D9 0
`define AUTC_TSC_WMASK 8'hF5
`define AUTC_TSC_RST 8'h00

// receive_status_control fields
`define AUTC_RSC_SERIAL_PORT_ENABLE 7
`define AUTC_RSC_RX9 6
`define AUTC_RSC_SINGLE_RECEIVE_ENABLE 5
`define AUTC_RSC_CONTINUOUS_RECEIVE_ENABLE 4
`define AUTC_RSC_ADDEN 3
`define AUTC_RSC_WMASK 8'hF8
`define AUTC_RSC_RST 8'h00

// Other reset values
`define AUTC_DIR_RST 2'b00
`define AUTC_BAUD_RST 8'h03

// Baud ticks per bit and master clock phases
`define AUTC_TPB_HIGH 7'd16
`define AUTC_TPB_LOW 7'd64
`define AUTC_MCK_RISE 2'd1
`define AUTC_MCK_FALL 2'd3

`endif

// ### autc_pkg.sv
// Types shared by the serial port design
package autc_pkg;

  // Frame state, Gray coded along idle-start-data-stop
  typedef enum logic [1:0] {
    AUTC_IDLE = 2'b00,
    AUTC_START = 2'b01,
    AUTC_DATA = 2'b11,
    AUTC_STOP = 2'b10
  } autc_state_t;

endpackage

// ### autc_tb.sv
// Self-checking bench: registers, async duplex, address frames, sync modes
`timescale 1ns/1ns
`include "autc_map.svh"
module tb;
  // Clock, reset and bus
  logic core_clk;
  logic rst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  // Pins, far-side drivers and resolved lines with pull-ups
  logic txck_pin_o, txck_pin_oe, rxdt_pin_o, rxdt_pin_oe;
  logic term_o, term_oe, term_nine, link_ck, link_oe;
  logic txck_line, rxdt_line;
  // Bench bookkeeping
  int num_errors, checked, cyc, n0, k;
  logic [7:0] cap;
  logic oe_seen;

  assign txck_line = txck_pin_oe ? txck_pin_o : (link_oe ? link_ck : 1'b1);
  assign rxdt_line = rxdt_pin_oe ? rxdt_pin_o : (term_oe ? term_o : 1'b1);

  autc_top dut (.core_clk(core_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .txck_pin_i(txck_line),
    .txck_pin_o(txck_pin_o), .txck_pin_oe(txck_pin_oe),
    .rxdt_pin_i(rxdt_line), .rxdt_pin_o(rxdt_pin_o),
    .rxdt_pin_oe(rxdt_pin_oe));

  autc_term #(.BIT_CLK(64)) term (.core_clk(core_clk), .tx_line(txck_line),
    .nine(term_nine), .rx_o(term_o), .rx_oe(term_oe));

  // 100 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Compare and count; unknowns never match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One single AHB-Lite transfer; waits on hready, never on a count
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(a, 1'b0, 32'h00000000, x);
    chk(x, exp);
  endtask

  // Bounded wait for the terminal to finish another frame
  task automatic wait_frame(input int from);
    int i;
    for (i = 0; i < 3000 && term.frames == from; i++) @(posedge core_clk);
  endtask

  // Sync master capture: data taken at each rising clock
  task automatic cap_master(output logic [7:0] v);
    int i;
    int n;
    logic prev;
    n = 0;
    prev = txck_pin_o;
    for (i = 0; i < 800 && n < 8; i++) begin
      @(posedge core_clk);
      if (txck_pin_o === 1'b1 && prev === 1'b0 && rxdt_pin_oe === 1'b1) begin
        v[n[2:0]] = rxdt_pin_o;
        n++;
      end
      prev = txck_pin_o;
    end
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      $display("[ERR] %0t run exceeded its cycle limit", $time);
      end_of_test();
    end
  end

  initial begin
    rst = 1'b1;
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'b010;
    {term_nine, link_ck, link_oe} = 3'b000;
    {num_errors, checked, cyc} = '0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    // Reset values, unmapped word, read-only and unused bits
    rd(`AUTC_TSC_OFF, 32'h02);
    rd(8'h00, 32'h00);
    wr(`AUTC_TSC_OFF, 32'hFF);
    rd(`AUTC_TSC_OFF, 32'hF7);
    $display("test registers done");
    // Async: send and receive at the same time
    wr(`AUTC_DIR_OFF, 32'hC0);
    wr(`AUTC_TSC_OFF, 32'h24);
    wr(`AUTC_RSC_OFF, 32'h90);
    n0 = term.frames;
    wr(`AUTC_TX_DATA_OFF, 32'hA5);
    fork
      term.send(9'h03C, 8);
      rd(`AUTC_TSC_OFF, 32'h24);
    join
    wait_frame(n0);
    repeat (40) @(posedge core_clk);
    chk({23'h0, term.last_word}, 32'h0A5);
    rd(`AUTC_RX_DATA_OFF, 32'h3C);
    $display("test async duplex done");
    // Nine-bit frame carries the ninth bit from the control register
    term_nine <= 1'b1;
    wr(`AUTC_TSC_OFF, 32'h65);
    n0 = term.frames;
    wr(`AUTC_TX_DATA_OFF, 32'h5A);
    wait_frame(n0);
    chk({23'h0, term.last_word}, 32'h15A);
    $display("test nine bit done");
    // Address detect: data frame dropped, address frame kept
    wr(`AUTC_RSC_OFF, 32'hD8);
    term.send(9'h033, 9);
    repeat (40) @(posedge core_clk);
    rd(`AUTC_STAT_OFF, 32'h00);
    term.send(9'h1C4, 9);
    repeat (40) @(posedge core_clk);
    rd(`AUTC_STAT_OFF, 32'h01);
    rd(`AUTC_RSC_OFF, 32'hD9);
    rd(`AUTC_RX_DATA_OFF, 32'hC4);
    $display("test address detect done");
    // Transmit disabled: byte waits, then goes once enabled
    term_nine <= 1'b0;
    wr(`AUTC_RSC_OFF, 32'h90);
    wr(`AUTC_TSC_OFF, 32'h04);
    n0 = term.frames;
    wr(`AUTC_TX_DATA_OFF, 32'h11);
    repeat (800) @(posedge core_clk);
    chk(term.frames, n0);
    rd(`AUTC_STAT_OFF, 32'h02);
    wr(`AUTC_TSC_OFF, 32'h24);
    wait_frame(n0);
    chk({23'h0, term.last_word}, 32'h011);
    chk(term.bad_frames, 0);
    $display("test transmit enable done");
    // Sync master: receive enable holds the transmitter off
    wr(`AUTC_TSC_OFF, 32'hB4);
    wr(`AUTC_TX_DATA_OFF, 32'h77);
    oe_seen = 1'b0;
    repeat (300) begin
      @(posedge core_clk);
      oe_seen = oe_seen | rxdt_pin_oe;
    end
    chk({31'h0, oe_seen}, 32'h0);
    wr(`AUTC_RSC_OFF, 32'h80);
    cap_master(cap);
    chk({24'h0, cap}, 32'h77);
    chk({31'h0, txck_pin_oe}, 32'h1);
    repeat (100) @(posedge core_clk);
    $display("test sync master done");
    // Sync slave: clock comes from the far side, only within the frame
    link_oe <= 1'b1;
    wr(`AUTC_TSC_OFF, 32'h34);
    repeat (2) @(posedge core_clk);
    chk({31'h0, txck_pin_oe}, 32'h0);
    wr(`AUTC_TX_DATA_OFF, 32'hC3);
    repeat (20) @(posedge core_clk);
    // 80 ns link clock: low 5 cycles, high 3, data taken at rise
    for (k = 0; k < 8; k++) begin
      repeat (5) @(posedge core_clk);
      link_ck <= 1'b1;
      cap[k[2:0]] = rxdt_pin_o;
      repeat (3) @(posedge core_clk);
      link_ck <= 1'b0;
    end
    repeat (8) @(posedge core_clk);
    chk({24'h0, cap}, 32'hC3);
    $display("test sync slave done");
    end_of_test();
  end
endmodule

// ### autc_term.sv
// Terminal model: async frame sender and decoder at the port's pins
`timescale 1ns/1ns
module autc_term #(
  parameter int BIT_CLK = 64 // Core clocks per bit at the chosen rate
) (
  // Clock
  input wire logic core_clk,
  // Line from the port and frame length select
  input wire logic tx_line,
  input wire logic nine,
  // Line into the port
  output logic rx_o,
  output logic rx_oe
);
  logic [8:0] last_word; // Last word decoded
  int frames; // Frames decoded so far
  int bad_frames; // Frames with a low stop bit

  // Idle: released, so the pull-up holds the line high
  initial begin
    rx_o = 1'b1;
    rx_oe = 1'b0;
    last_word = 9'h000;
    frames = 0;
    bad_frames = 0;
  end

  task automatic send(input logic [8:0] word, input int nbits);
    int i;
    @(posedge core_clk);
    rx_oe <= 1'b1;
    rx_o <= 1'b0;
    repeat (BIT_CLK) @(posedge core_clk);
    for (i = 0; i < nbits; i++) begin
      rx_o <= word[i];
      repeat (BIT_CLK) @(posedge core_clk);
    end
    rx_o <= 1'b1;
    repeat (BIT_CLK) @(posedge core_clk);
    // Released after the stop bit, not held at its last value
    rx_oe <= 1'b0;
  endtask

  always begin
    int i;
    logic [8:0] w;
    @(posedge core_clk);
    if (tx_line === 1'b0) begin
      w = 9'h000;
      repeat (BIT_CLK / 2) @(posedge core_clk);
      for (i = 0; i < (nine ? 9 : 8); i++) begin
        repeat (BIT_CLK) @(posedge core_clk);
        w[i] = tx_line;
      end
      repeat (BIT_CLK) @(posedge core_clk);
      // Stop bit must read high
      if (tx_line !== 1'b1) begin
        bad_frames++;
      end
      last_word = w;
      frames++;
    end
  end
endmodule

// ### autc_top.sv
// Serial port with addressable frames behind an AHB-Lite slave
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ns
`include "autc_map.svh"
module autc_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Transmit or clock pin
  input wire logic txck_pin_i,
  output logic txck_pin_o,
  output logic txck_pin_oe,
  // Receive or data pin
  input wire logic rxdt_pin_i,
  output logic rxdt_pin_o,
  output logic rxdt_pin_oe
);

  // Frame length in bits
  function automatic logic [3:0] nbits(input logic nine);
    nbits = nine ? 4'd9 : 4'd8;
  endfunction

  // Baud ticks per bit in asynchronous mode
  function automatic logic [6:0] ticks_per_bit(input logic high);
    ticks_per_bit = high ? `AUTC_TPB_HIGH : `AUTC_TPB_LOW;
  endfunction

  // Word-aligned register hit
  function automatic logic is_reg(input logic [31:0] a, input logic [7:0] o);
    is_reg = (a[31:8] == 24'h000000) && (a[7:0] == o);
  endfunction

  // Software registers
  logic [7:0] tsc_q;         // transmit_status_control storage
  logic [7:0] rsc_q;         // receive_status_control storage
  logic [1:0] dir_q;         // port_c_direction bits 7:6
  logic [7:0] baud_q;        // Baud divisor
  logic [7:0] tx_buf_q;      // Transmit holding byte
  logic tx_buf_full_q;       // Holding byte waiting
  logic [7:0] rx_buf_q;      // Received byte
  logic rx_d9_q;             // Received ninth bit
  logic rx_full_q;           // Received byte waiting
  logic oerr_q;              // Overrun seen
  // Bus pipeline
  logic wr_pend_q;           // Write data phase pending
  logic [7:0] wr_addr_q;     // Write offset
  logic [7:0] rd_val;        // Read mux
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  // Pin synchronisers; stage one feeds stage two only
  logic txck_s1_q, txck_s2_q, txck_s3_q;
  logic rxdt_s1_q, rxdt_s2_q;
  // Transmitter
  autc_pkg::autc_state_t tx_state_q;
  logic [6:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [8:0] tx_sh_q;       // transmit_shift_register
  logic tx_line_q;
  // Receiver
  autc_pkg::autc_state_t rx_state_q;
  logic [6:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [8:0] rx_sh_q;
  logic rx_ferr_q;
  logic rx_done_q;           // Frame complete, one cycle
  // Master clock phase
  logic [1:0] mck_cnt_q;
  // Pin output flops
  logic txck_o_q, txck_oe_q, rxdt_o_q, rxdt_oe_q;
  // Baud tick
  logic tick;

  // Decoded controls
  wire acc = hsel & hready & htrans[1];
  wire sync = tsc_q[`AUTC_TSC_SYNC];
  wire master = tsc_q[`AUTC_TSC_CLKSRC];
  wire nine_tx = tsc_q[`AUTC_TSC_NINE];
  wire rx9 = rsc_q[`AUTC_RSC_RX9];
  wire continuous_receive_enable = rsc_q[`AUTC_RSC_CONTINUOUS_RECEIVE_ENABLE];
  wire rx_req = rsc_q[`AUTC_RSC_SINGLE_RECEIVE_ENABLE] | continuous_receive_enable;
  wire [6:0] tpb = ticks_per_bit(tsc_q[`AUTC_TSC_BAUD_SPEED_RANGE_SELECT]);
  wire [6:0] tpb_half = tpb >> 1;
  wire rxd = rxdt_s2_q;
  wire pins_on = rsc_q[`AUTC_RSC_SERIAL_PORT_ENABLE] & dir_q[1] & dir_q[0];
  wire tx_allow = tsc_q[`AUTC_TSC_TRANSMIT_ENABLE] & ~(sync & rx_req) & pins_on;
  wire tx_busy = tx_state_q != autc_pkg::AUTC_IDLE;
  wire rx_busy = rx_state_q != autc_pkg::AUTC_IDLE;
  wire rx_keep = pins_on & (sync ? rx_req : continuous_receive_enable);
  wire mck_run = sync & master & (tx_busy | rx_busy);
  wire m_rise = mck_run & tick & (mck_cnt_q == `AUTC_MCK_RISE);
  wire m_fall = mck_run & tick & (mck_cnt_q == `AUTC_MCK_FALL);
  wire ck_rise = txck_s2_q & ~txck_s3_q;
  wire ck_fall = ~txck_s2_q & txck_s3_q;
  wire s_sample = master ? m_rise : ck_rise;
  wire s_shift = master ? m_fall : ck_fall;
  wire rd_clear = acc & ~hwrite & is_reg(haddr, `AUTC_RX_DATA_OFF);
  wire tx_wr = wr_pend_q & (wr_addr_q == `AUTC_TX_DATA_OFF);
  wire tx_load = ~tx_busy & tx_buf_full_q & tx_allow;
  wire rx_accept = rx_done_q &
                   ~(rsc_q[`AUTC_RSC_ADDEN] & rx9 & ~rx_sh_q[8]);
  wire oerr_set = rx_accept & rx_full_q & ~rd_clear;
  wire single_receive_enable_done = rx_done_q & sync & master;

  // Baud tick source
  autc_baud_gen u_baud (
    .core_clk(core_clk),
    .rst(rst),
    .divisor(baud_q),
    .tick(tick)
  );

  // Bus address phase; zero wait states, always OKAY
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b1;
    end else begin
      wr_pend_q <= acc & hwrite & (haddr[31:8] == 24'h000000);
      hreadyout_q <= 1'b1;
      if (acc) begin
        wr_addr_q <= haddr[7:0];
      end
      if (acc & ~hwrite) begin
        hrdata_q <= {24'h000000, rd_val};
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_val = 8'h00;
    if (is_reg(haddr, `AUTC_TSC_OFF)) begin
      rd_val = {tsc_q[7:4], 1'b0, tsc_q[2], ~tx_busy, tsc_q[0]};
    end else if (is_reg(haddr, `AUTC_TX_DATA_OFF)) begin
      rd_val = tx_buf_q;
    end else if (is_reg(haddr, `AUTC_RX_DATA_OFF)) begin
      rd_val = rx_buf_q;
    end else if (is_reg(haddr, `AUTC_RSC_OFF)) begin
      rd_val = {rsc_q[7:3], rx_ferr_q, oerr_q, rx_d9_q};
    end else if (is_reg(haddr, `AUTC_BAUD_OFF)) begin
      rd_val = baud_q;
    end else if (is_reg(haddr, `AUTC_DIR_OFF)) begin
      rd_val = {dir_q, 6'h00};
    end else if (is_reg(haddr, `AUTC_STAT_OFF)) begin
      rd_val = {6'h00, tx_buf_full_q, rx_full_q};
    end
  end

  // Plain control registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tsc_q <= `AUTC_TSC_RST;
      baud_q <= `AUTC_BAUD_RST;
      dir_q <= `AUTC_DIR_RST;
    end else if (wr_pend_q) begin
      if (wr_addr_q == `AUTC_TSC_OFF) begin
        tsc_q <= hwdata[7:0] & `AUTC_TSC_WMASK;
      end else if (wr_addr_q == `AUTC_BAUD_OFF) begin
        baud_q <= hwdata[7:0];
      end else if (wr_addr_q == `AUTC_DIR_OFF) begin
        dir_q <= hwdata[7:6];
      end
    end
  end

  // Receive control; single receive drops after one master frame
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rsc_q <= `AUTC_RSC_RST;
    end else if (wr_pend_q && wr_addr_q == `AUTC_RSC_OFF) begin
      rsc_q <= hwdata[7:0] & `AUTC_RSC_WMASK;
    end else if (single_receive_enable_done) begin
      rsc_q[`AUTC_RSC_SINGLE_RECEIVE_ENABLE] <= 1'b0;
    end
  end

  // Overrun flag; a new overrun beats the clear by dropping continuous_receive_enable
  always_ff @(posedge core_clk) begin
    if (rst) begin
      oerr_q <= 1'b0;
    end else if (oerr_set) begin
      oerr_q <= 1'b1;
    end else if (~continuous_receive_enable) begin
      oerr_q <= 1'b0;
    end
  end

  // Transmit holding byte; a write beats the load clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_buf_q <= 8'h00;
      tx_buf_full_q <= 1'b0;
    end else if (tx_wr) begin
      tx_buf_q <= hwdata[7:0];
      tx_buf_full_q <= 1'b1;
    end else if (tx_load) begin
      tx_buf_full_q <= 1'b0;
    end
  end

  // Received word delivery; overrun drops the new word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_buf_q <= 8'h00;
      rx_d9_q <= 1'b0;
      rx_full_q <= 1'b0;
    end else if (rx_accept & ~oerr_set) begin
      rx_buf_q <= rx_sh_q[7:0];
      rx_d9_q <= rx_sh_q[8];
      rx_full_q <= 1'b1;
    end else if (rd_clear) begin
      rx_full_q <= 1'b0;
    end
  end

  // Pin synchronisers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      // Idle level of the pulled-up clock pin, so no false edge
      txck_s1_q <= 1'b1;
      txck_s2_q <= 1'b1;
      txck_s3_q <= 1'b1;
      rxdt_s1_q <= 1'b1;
      rxdt_s2_q <= 1'b1;
    end else begin
      txck_s1_q <= txck_pin_i;
      txck_s2_q <= txck_s1_q;
      txck_s3_q <= txck_s2_q;
      rxdt_s1_q <= rxdt_pin_i;
      rxdt_s2_q <= rxdt_s1_q;
    end
  end

  // Master clock phase: low for two ticks, high for two
  always_ff @(posedge core_clk) begin
    if (rst || !mck_run || tx_load) begin
      // A new frame always starts from the low phase
      mck_cnt_q <= 2'd0;
    end else if (tick) begin
      mck_cnt_q <= mck_cnt_q + 2'd1;
    end
  end

  // Transmitter; clearing enable aborts the frame at once
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_state_q <= autc_pkg::AUTC_IDLE;
      tx_cnt_q <= 7'd0;
      tx_bit_q <= 4'd0;
      tx_sh_q <= 9'h000;
      tx_line_q <= 1'b1;
    end else if (!tx_allow) begin
      tx_state_q <= autc_pkg::AUTC_IDLE;
      tx_line_q <= 1'b1;
    end else begin
      case (tx_state_q)
        autc_pkg::AUTC_IDLE: begin
          tx_line_q <= 1'b1;
          if (tx_load) begin
            tx_sh_q <= {tsc_q[`AUTC_TSC_D9], tx_buf_q};
            tx_cnt_q <= 7'd0;
            tx_bit_q <= 4'd0;
            if (sync) begin
              tx_state_q <= autc_pkg::AUTC_DATA;
              tx_line_q <= tx_buf_q[0];
            end else begin
              tx_state_q <= autc_pkg::AUTC_START;
              tx_line_q <= 1'b0;
            end
          end
        end
        autc_pkg::AUTC_START: begin
          if (tick) begin
            if (tx_cnt_q == tpb - 7'd1) begin
              tx_cnt_q <= 7'd0;
              tx_state_q <= autc_pkg::AUTC_DATA;
              tx_line_q <= tx_sh_q[0];
            end else begin
              tx_cnt_q <= tx_cnt_q + 7'd1;
            end
          end
        end
        autc_pkg::AUTC_DATA: begin
          if (sync) begin
            if (s_sample) begin
              if (tx_bit_q == nbits(nine_tx) - 4'd1) begin
                // Last bit held until its clock falls
                tx_state_q <= autc_pkg::AUTC_STOP;
              end else begin
                tx_bit_q <= tx_bit_q + 4'd1;
              end
            end else if (s_shift) begin
              tx_line_q <= tx_sh_q[tx_bit_q];
            end
          end else if (tick) begin
            if (tx_cnt_q == tpb - 7'd1) begin
              tx_cnt_q <= 7'd0;
              if (tx_bit_q == nbits(nine_tx) - 4'd1) begin
                tx_state_q <= autc_pkg::AUTC_STOP;
                tx_line_q <= 1'b1;
              end else begin
                tx_bit_q <= tx_bit_q + 4'd1;
                tx_line_q <= tx_sh_q[tx_bit_q + 4'd1];
              end
            end else begin
              tx_cnt_q <= tx_cnt_q + 7'd1;
            end
          end
        end
        autc_pkg::AUTC_STOP: begin
          if (sync) begin
            // Data pin released only after the last high phase
            if (s_shift) begin
              tx_state_q <= autc_pkg::AUTC_IDLE;
            end
          end else if (tick) begin
            if (tx_cnt_q == tpb - 7'd1) begin
              tx_state_q <= autc_pkg::AUTC_IDLE;
            end else begin
              tx_cnt_q <= tx_cnt_q + 7'd1;
            end
          end
        end
        default: tx_state_q <= autc_pkg::AUTC_IDLE;
      endcase
    end
  end

  // Receiver; runs beside the transmitter in asynchronous mode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_state_q <= autc_pkg::AUTC_IDLE;
      rx_cnt_q <= 7'd0;
      rx_bit_q <= 4'd0;
      rx_sh_q <= 9'h000;
      rx_ferr_q <= 1'b0;
      rx_done_q <= 1'b0;
    end else if (!rx_keep) begin
      rx_state_q <= autc_pkg::AUTC_IDLE;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      case (rx_state_q)
        autc_pkg::AUTC_IDLE: begin
          rx_cnt_q <= 7'd0;
          rx_bit_q <= 4'd0;
          if (sync) begin
            rx_state_q <= autc_pkg::AUTC_DATA;
            rx_sh_q <= 9'h000;
          end else if (!rxd) begin
            rx_state_q <= autc_pkg::AUTC_START;
            rx_sh_q <= 9'h000;
          end
        end
        autc_pkg::AUTC_START: begin
          if (tick) begin
            if (rx_cnt_q == tpb_half - 7'd1) begin
              rx_cnt_q <= 7'd0;
              rx_state_q <= rxd ? autc_pkg::AUTC_IDLE
                                : autc_pkg::AUTC_DATA;
            end else begin
              rx_cnt_q <= rx_cnt_q + 7'd1;
            end
          end
        end
        autc_pkg::AUTC_DATA: begin
          if (sync) begin
            if (s_sample) begin
              rx_sh_q[rx_bit_q] <= rxd;
              if (rx_bit_q == nbits(rx9) - 4'd1) begin
                rx_state_q <= autc_pkg::AUTC_IDLE;
                rx_ferr_q <= 1'b0;
                rx_done_q <= 1'b1;
              end else begin
                rx_bit_q <= rx_bit_q + 4'd1;
              end
            end
          end else if (tick) begin
            if (rx_cnt_q == tpb - 7'd1) begin
              rx_cnt_q <= 7'd0;
              rx_sh_q[rx_bit_q] <= rxd;
              if (rx_bit_q == nbits(rx9) - 4'd1) begin
                rx_state_q <= autc_pkg::AUTC_STOP;
              end else begin
                rx_bit_q <= rx_bit_q + 4'd1;
              end
            end else begin
              rx_cnt_q <= rx_cnt_q + 7'd1;
            end
          end
        end
        autc_pkg::AUTC_STOP: begin
          if (tick) begin
            if (rx_cnt_q == tpb - 7'd1) begin
              rx_state_q <= autc_pkg::AUTC_IDLE;
              rx_ferr_q <= ~rxd;
              rx_done_q <= 1'b1;
            end else begin
              rx_cnt_q <= rx_cnt_q + 7'd1;
            end
          end
        end
        default: rx_state_q <= autc_pkg::AUTC_IDLE;
      endcase
    end
  end

  // Pin drivers; slave mode leaves the clock pin as input
  always_ff @(posedge core_clk) begin
    if (rst) begin
      txck_o_q <= 1'b0;
      txck_oe_q <= 1'b0;
      rxdt_o_q <= 1'b0;
      rxdt_oe_q <= 1'b0;
    end else begin
      txck_o_q <= sync ? (master & mck_cnt_q[1]) : tx_line_q;
      txck_oe_q <= pins_on & (~sync | master);
      rxdt_o_q <= tx_line_q;
      rxdt_oe_q <= pins_on & sync & tx_busy;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign txck_pin_o = txck_o_q;
  assign txck_pin_oe = txck_oe_q;
  assign rxdt_pin_o = rxdt_o_q;
  assign rxdt_pin_oe = rxdt_oe_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Stop entered only after the selected number of data bits
  sequence tx_data_to_stop;
    tx_state_q == autc_pkg::AUTC_DATA ##1 tx_state_q == autc_pkg::AUTC_STOP;
  endsequence

  AST_FULL_DUPLEX: assert property (
    !sync && rx_keep && !rx_busy && !rxd && tx_busy
    |=> rx_state_q == autc_pkg::AUTC_START)
    else $error("receiver did not start beside transmitter");
  AST_HALF_DUPLEX: assert property (
    sync && $past(sync) && rx_busy |-> !tx_busy)
    else $error("both directions active in synchronous mode");
  AST_ADDR_FILTER: assert property (
    rx_done_q && rx9 && rsc_q[`AUTC_RSC_ADDEN] && !rx_sh_q[8]
    |=> $stable(rx_buf_q))
    else $error("data frame passed address filter");
  AST_FRAME_LEN: assert property (
    tx_data_to_stop |-> tx_bit_q == nbits(nine_tx) - 4'd1)
    else $error("frame length does not match nine-bit select");
  AST_TX_BLOCKED: assert property (
    !tsc_q[`AUTC_TSC_TRANSMIT_ENABLE] |=> tx_state_q == autc_pkg::AUTC_IDLE)
    else $error("transmitter active while disabled");
  AST_RX_PRIORITY: assert property (
    sync && rx_req ##1 sync && rx_req |=> !rxdt_pin_oe)
    else $error("data pin driven while receive enabled");
  AST_CLK_SOURCE: assert property (
    sync && pins_on |=> txck_pin_oe == $past(master))
    else $error("clock pin drive does not follow clock source");

endmodule
